// ---- dal_alarm_latch.v ----
// Alarm latch, reset manager, keypad display select and APB registers
//
// Operation
// - While any alarm is latched, the display shows its alarm code.
// - Outside controller pulses the reset input on then off to clear.
// - Keypad reset function in additional function mode also resets alarms.
// - Up and down held together one second on alarm screen resets.
// - After a reset the display returns to the initial display item.
// - Reset clears overcurrent, overspeed, voltage, overload and similar alarms.
// - Reset leaves encoder, circuit, memory and absolute-data alarms latched; the code clears encoder link fault on reset.
// - Non-resettable alarms outside the preset group are released only by a power cycle.
// - Position preset clears absolute data lost and multi-turn overflow.
// - No reset method releases a non-resettable alarm.
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/10ps
`include "dal_regs.vh"

module dal_alarm_latch #(
    parameter HOLD_CYCLES = `DAL_HOLD_CYCLES,
    parameter CNT_W = 28,
    parameter DISP_W = 8
) (
    input wire sys_clk,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Fault detectors, same clock, level while the fault is present
    input wire [`DAL_ALARM_W-1:0] alarm_cond,
    // Discrete alarm reset input pin, active high
    input wire alarm_reset_in,
    // Keypad pins, active low while pressed
    input wire key_up_n,
    input wire key_down_n,
    // Keypad menu strobes, same clock, one-cycle pulses
    input wire keypad_reset_function,
    input wire position_preset,
    // Display and status
    output reg disp_alarm_r,
    output reg [DISP_W-1:0] disp_code_r,
    output reg [`DAL_ALARM_W-1:0] alarm_r,
    output reg reset_done_r,
    output reg irq_r
);

    // Hold count is cut to the counter width on purpose; CNT_W must be wide
    // enough for HOLD_CYCLES or the two-key reset fires early
    localparam [31:0] HOLD_LAST_W = HOLD_CYCLES - 1;
    localparam [CNT_W-1:0] HOLD_LAST = HOLD_LAST_W[CNT_W-1:0];
    localparam [`DAL_ALARM_W-1:0] RST_MASK = `DAL_RESETTABLE_MASK;
    localparam [`DAL_ALARM_W-1:0] PRE_MASK = `DAL_PRESET_MASK;

    // Two-key hold states
    localparam [2:0] KEY_IDLE = 3'b001;
    localparam [2:0] KEY_HOLD = 3'b010;
    localparam [2:0] KEY_DONE = 3'b100;

    // Pin synchronisers
    reg rst_in_s1_r;
    reg rst_in_s2_r;
    reg rst_in_s3_r;
    reg up_s1_r;
    reg up_s2_r;
    reg dn_s1_r;
    reg dn_s2_r;

    // Key hold machine
    reg [2:0] key_state_r;
    reg [2:0] key_state_nxt;
    reg [CNT_W-1:0] hold_cnt_r;
    reg [CNT_W-1:0] hold_cnt_nxt;
    reg key_reset;

    // Software visible state
    reg [DISP_W-1:0] init_disp_r;
    reg [DISP_W-1:0] disp_item_r;
    reg [`DAL_IRQ_W-1:0] irq_stat_r;
    reg [`DAL_IRQ_W-1:0] irq_mask_r;
    reg sw_reset_r;
    reg sw_preset_r;

    // Derived terms
    wire both_keys;
    wire pin_reset;
    wire reset_req;
    wire preset_req;
    wire apb_acc;
    wire apb_wr;
    wire apb_rd_setup;
    wire wr_ctrl;
    wire wr_init;
    wire wr_mask;
    wire wr_stat;
    wire [`DAL_ALARM_W-1:0] clear_mask;
    wire [`DAL_ALARM_W-1:0] alarm_nxt;
    wire new_alarm;
    wire [`DAL_IRQ_W-1:0] irq_set;
    wire [`DAL_IRQ_W-1:0] irq_clr;
    wire [`DAL_IRQ_W-1:0] irq_stat_nxt;
    reg addr_ok;
    reg [31:0] rd_mux;

    // Lowest set alarm index; the lowest-numbered set bit wins the display, whatever order the alarms came in
    function [DISP_W-1:0] first_alarm;
        input [`DAL_ALARM_W-1:0] vec;
        integer i;
        begin
            first_alarm = {DISP_W{1'b0}};
            for (i = `DAL_ALARM_W - 1; i >= 0; i = i - 1) begin
                if (vec[i]) begin
                    first_alarm = i[DISP_W-1:0];
                end
            end
        end
    endfunction

    // Two flops before any logic looks at a pin; third flop is for the edge
    // Keys reset to released, matching their idle level, so no false press
    always @(posedge sys_clk) begin
        if (rst) begin
            rst_in_s1_r <= 1'b0;
            rst_in_s2_r <= 1'b0;
            rst_in_s3_r <= 1'b0;
            up_s1_r <= 1'b0;
            up_s2_r <= 1'b0;
            dn_s1_r <= 1'b0;
            dn_s2_r <= 1'b0;
        end else begin
            rst_in_s1_r <= alarm_reset_in;
            rst_in_s2_r <= rst_in_s1_r;
            rst_in_s3_r <= rst_in_s2_r;
            up_s1_r <= ~key_up_n;
            up_s2_r <= up_s1_r;
            dn_s1_r <= ~key_down_n;
            dn_s2_r <= dn_s1_r;
        end
    end

    // Release edge only, so a stuck-on input never clears new alarms
    assign pin_reset = rst_in_s3_r & ~rst_in_s2_r;
    assign both_keys = up_s2_r & dn_s2_r;

    // Hold timer for the two-key reset; fires once per press
    // Limitation: counts sys_clk cycles, so HOLD_CYCLES must follow the clock
    always @* begin
        key_state_nxt = key_state_r;
        hold_cnt_nxt = hold_cnt_r;
        key_reset = 1'b0;
        case (key_state_r)
            KEY_IDLE: begin
                // Counter parked at zero until both keys show
                hold_cnt_nxt = {CNT_W{1'b0}};
                if (both_keys && disp_alarm_r) begin
                    key_state_nxt = KEY_HOLD;
                end
            end
            KEY_HOLD: begin
                // Any release or leaving the alarm screen restarts timing
                if (!both_keys || !disp_alarm_r) begin
                    key_state_nxt = KEY_IDLE;
                end else if (hold_cnt_r == HOLD_LAST) begin
                    key_reset = 1'b1;
                    key_state_nxt = KEY_DONE;
                end else begin
                    hold_cnt_nxt = hold_cnt_r + 1'b1;
                end
            end
            KEY_DONE: begin
                // Wait for a key release before a second reset can fire
                if (!both_keys) begin
                    key_state_nxt = KEY_IDLE;
                end
            end
            default: begin
                // A corrupted one-hot code recovers to idle
                key_state_nxt = KEY_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            key_state_r <= KEY_IDLE;
            hold_cnt_r <= {CNT_W{1'b0}};
        end else begin
            key_state_r <= key_state_nxt;
            hold_cnt_r <= hold_cnt_nxt;
        end
    end

    // All four reset sources (pin, keypad function, ctrl register, two-key hold) merge into one request
    // Requests from several sources in one cycle act as a single reset
    assign reset_req = pin_reset | keypad_reset_function | sw_reset_r |
                       key_reset;
    assign preset_req = position_preset | sw_preset_r;

    // Only the resettable group can ever be cleared by a reset request
    assign clear_mask = (reset_req ? RST_MASK : {`DAL_ALARM_W{1'b0}}) |
                        (preset_req ? PRE_MASK : {`DAL_ALARM_W{1'b0}});

    // A fault present in the clear cycle keeps its alarm set
    assign alarm_nxt = (alarm_r & ~clear_mask) | alarm_cond;
    assign new_alarm = |(alarm_cond & ~alarm_r);

    // Alarm latch; only power-on reset clears the whole vector
    always @(posedge sys_clk) begin
        if (rst) begin
            alarm_r <= {`DAL_ALARM_W{1'b0}};
        end else begin
            alarm_r <= alarm_nxt;
        end
    end

    // Display: alarm code overrides normal content while anything is latched
    // The code follows alarm_nxt, one level of logic deeper, so display and
    // latch change on the same edge
    always @(posedge sys_clk) begin
        if (rst) begin
            disp_alarm_r <= 1'b0;
            disp_code_r <= {DISP_W{1'b0}};
            disp_item_r <= {DISP_W{1'b0}};
            reset_done_r <= 1'b0;
        end else begin
            reset_done_r <= reset_req;
            if (reset_req) begin
                disp_item_r <= init_disp_r;
            end
            disp_alarm_r <= |alarm_nxt;
            if (|alarm_nxt) begin
                disp_code_r <= first_alarm(alarm_nxt);
            end else if (reset_req) begin
                disp_code_r <= init_disp_r;
            end else begin
                disp_code_r <= disp_item_r;
            end
        end
    end

    // APB decode; one wait state, pready rises in the second access cycle
    assign apb_acc = psel & penable & pready;
    assign apb_wr = apb_acc & pwrite;
    assign apb_rd_setup = psel & penable & ~pready;

    // Per-register write strobes, only on the committing access edge;
    // writes to read-only or unmapped offsets match none and are dropped
    assign wr_ctrl = apb_wr && (paddr == `DAL_CTRL_OFS);
    assign wr_init = apb_wr && (paddr == `DAL_INIT_DISP_OFS);
    assign wr_mask = apb_wr && (paddr == `DAL_IRQ_MASK_OFS);
    assign wr_stat = apb_wr && (paddr == `DAL_IRQ_STAT_OFS);

    always @* begin
        addr_ok = 1'b1;
        rd_mux = 32'h00000000;
        case (paddr)
            `DAL_CTRL_OFS: begin
                rd_mux = 32'h00000000;
            end
            `DAL_INIT_DISP_OFS: begin
                rd_mux[DISP_W-1:0] = init_disp_r;
            end
            `DAL_ALARM_OFS: begin
                rd_mux[`DAL_ALARM_W-1:0] = alarm_r;
            end
            `DAL_IRQ_STAT_OFS: begin
                rd_mux[`DAL_IRQ_W-1:0] = irq_stat_r;
            end
            `DAL_IRQ_MASK_OFS: begin
                rd_mux[`DAL_IRQ_W-1:0] = irq_mask_r;
            end
            `DAL_DISPLAY_OFS: begin
                rd_mux[DISP_W-1:0] = disp_code_r;
                rd_mux[31] = disp_alarm_r;
            end
            `DAL_HOLD_ALARM_OFS: begin
                rd_mux[`DAL_ALARM_W-1:0] = alarm_r & ~RST_MASK;
            end
            default: begin
                // Hole: flagged with pslverr, reads give zero
                addr_ok = 1'b0;
            end
        endcase
    end

    // Read data is caught in the wait cycle so it stands with pready
    always @(posedge sys_clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apb_rd_setup;
            pslverr <= apb_rd_setup & ~addr_ok;
            if (apb_rd_setup && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // Software registers; ctrl strobes self-clear after one cycle
    always @(posedge sys_clk) begin
        if (rst) begin
            init_disp_r <= `DAL_INIT_DISP_RST;
            irq_mask_r <= `DAL_IRQ_MASK_RST;
            sw_reset_r <= 1'b0;
            sw_preset_r <= 1'b0;
        end else begin
            sw_reset_r <= 1'b0;
            sw_preset_r <= 1'b0;
            // A zero written to a strobe bit leaves it idle
            if (wr_ctrl) begin
                sw_reset_r <= pwdata[`DAL_CTRL_KEYPAD_RESET];
                sw_preset_r <= pwdata[`DAL_CTRL_POS_PRESET];
            end
            if (wr_init) begin
                init_disp_r <= pwdata[DISP_W-1:0];
            end
            if (wr_mask) begin
                irq_mask_r <= pwdata[`DAL_IRQ_W-1:0];
            end
        end
    end

    // Sticky events, write one to clear; a new event beats its clear
    // irq_r follows the next status so it rises on the same edge as the bit
    assign irq_set[`DAL_IRQ_NEW_ALARM] = new_alarm;
    assign irq_set[`DAL_IRQ_RESET_DONE] = reset_req;
    assign irq_clr = wr_stat ? pwdata[`DAL_IRQ_W-1:0] : {`DAL_IRQ_W{1'b0}};
    assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;

    always @(posedge sys_clk) begin
        if (rst) begin
            irq_stat_r <= {`DAL_IRQ_W{1'b0}};
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_r <= |(irq_stat_nxt & irq_mask_r);
        end
    end

endmodule

// ---- dal_regs.vh ----
// Register map, alarm layout and timing constants for the alarm latch
`ifndef DAL_REGS_VH
`define DAL_REGS_VH

// Register byte offsets
`define DAL_CTRL_OFS 8'h00
`define DAL_INIT_DISP_OFS 8'h04
`define DAL_ALARM_OFS 8'h08
`define DAL_IRQ_STAT_OFS 8'h0c
`define DAL_IRQ_MASK_OFS 8'h10
`define DAL_DISPLAY_OFS 8'h14
`define DAL_HOLD_ALARM_OFS 8'h18

// Control register fields (write-only strobes, read as zero)
`define DAL_CTRL_KEYPAD_RESET 0
`define DAL_CTRL_POS_PRESET 1

// Interrupt status and mask fields
`define DAL_IRQ_NEW_ALARM 0
`define DAL_IRQ_RESET_DONE 1
`define DAL_IRQ_W 2

// Reset values
`define DAL_INIT_DISP_RST 8'h00
`define DAL_IRQ_MASK_RST 2'h0

// Alarm vector layout
`define DAL_ALARM_W 26
`define DAL_OVERCURRENT_FIRST 0
`define DAL_OVERCURRENT_SECOND 1
`define DAL_OVERCURRENT_THIRD 2
`define DAL_OVERSPEED 3
`define DAL_CONTROL_SUPPLY_UNDERVOLTAGE 4
`define DAL_OVERVOLTAGE 5
`define DAL_ENCODER_FAULT_FIRST 6
`define DAL_ENCODER_FAULT_SECOND 7
`define DAL_CIRCUIT_TROUBLE 8
`define DAL_MEMORY_ERROR 9
`define DAL_ENCODER_LINK_FAULT 10
`define DAL_ENCODER_MATCH_FAULT 11
`define DAL_CONTROL_SIGNAL_FAULT 12
`define DAL_OVERLOAD_FIRST 13
`define DAL_OVERLOAD_SECOND 14
`define DAL_MAIN_SUPPLY_UNDERVOLTAGE 15
`define DAL_REGEN_TRANSISTOR_FAULT 16
`define DAL_DEVIATION_OVERFLOW 17
`define DAL_DRIVE_OVERHEAT 18
`define DAL_ABSOLUTE_DATA_LOST_FIRST 19
`define DAL_ABSOLUTE_DATA_LOST_SECOND 20
`define DAL_ABSOLUTE_DATA_LOST_THIRD 21
`define DAL_MULTITURN_OVERFLOW 22
`define DAL_EXTERNAL_TERMINAL_ALARM 23
`define DAL_SPEED_RUNAWAY 24
`define DAL_HOMING_TIMEOUT 25

// Alarms released by any reset request
`define DAL_RESETTABLE_MASK 26'h386e43f
// Alarms released by a position preset
`define DAL_PRESET_MASK 26'h0780000

// Two-key hold time
`define DAL_HOLD_TIME_MS 1000
`define DAL_CLK_MHZ 250
`define DAL_HOLD_CYCLES (`DAL_HOLD_TIME_MS * 1000 * `DAL_CLK_MHZ)

`endif

// ---- dal_props_properties.sv ----
// Concurrent checks on the alarm latch ports
`timescale 1ns/10ps
`include "dal_regs.vh"
module dal_props #(
    parameter DISP_W = 8
) (
    input wire sys_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [`DAL_ALARM_W-1:0] alarm_cond,
    input wire alarm_reset_in,
    input wire key_up_n,
    input wire key_down_n,
    input wire keypad_reset_function,
    input wire position_preset,
    input wire disp_alarm_r,
    input wire [DISP_W-1:0] disp_code_r,
    input wire [`DAL_ALARM_W-1:0] alarm_r,
    input wire reset_done_r,
    input wire irq_r
);
    // Bits that only a power cycle may release
    localparam [25:0] KEEP = ~(`DAL_RESETTABLE_MASK | `DAL_PRESET_MASK);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_LATCH: assert property (
        alarm_cond != 0 |=> (alarm_r & $past(alarm_cond)) == $past(alarm_cond))
        else $error("fault level not latched");
    AST_DISP: assert property (disp_alarm_r == (alarm_r != 0))
        else $error("alarm screen flag wrong");
    AST_CODE: assert property (
        alarm_r[6] && alarm_r[5:0] == 6'h00 |-> disp_code_r == 6)
        else $error("alarm code wrong");
    AST_KEEP: assert property (
        (($past(alarm_r) & ~alarm_r) & KEEP) == 0)
        else $error("non-resettable alarm released");
    AST_KEY_CLR: assert property (
        keypad_reset_function |=>
        (alarm_r & `DAL_RESETTABLE_MASK & ~$past(alarm_cond)) == 0)
        else $error("keypad reset left alarm");
    AST_PRESET: assert property (
        position_preset |-> ##[1:3] (alarm_r & `DAL_PRESET_MASK) == 0)
        else $error("preset left alarm");
    AST_PIN: assert property (
        $fell(alarm_reset_in) |-> ##[2:6] reset_done_r)
        else $error("pin pulse gave no reset");
    AST_HELD: assert property (alarm_reset_in [*8] |-> !reset_done_r)
        else $error("held pin reset");
    AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after one wait");
    cover property (keypad_reset_function && alarm_r != 0);
    cover property ($fell(alarm_reset_in));
    cover property (pslverr);
endmodule
bind dal_alarm_latch dal_props #(.DISP_W(DISP_W)) u_props (.sys_clk, .rst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .alarm_cond, .alarm_reset_in, .key_up_n, .key_down_n,
    .keypad_reset_function, .position_preset, .disp_alarm_r, .disp_code_r,
    .alarm_r, .reset_done_r, .irq_r);

// ---- dal_keypad_model.sv ----
// Keypad operator and discrete reset input model
`timescale 1ns/10ps
module dal_keypad_model (
    input wire sys_clk,
    output logic alarm_reset_in,
    output logic key_up_n,
    output logic key_down_n,
    output logic keypad_reset_function,
    output logic position_preset
);
    // Idle: keys released (pulled high), pin off, no strobes
    initial begin
        alarm_reset_in = 1'b0;
        key_up_n = 1'b1;
        key_down_n = 1'b1;
        keypad_reset_function = 1'b0;
        position_preset = 1'b0;
    end
    // Pin level held by the outside controller
    task rst_pin(input logic lvl);
        @(posedge sys_clk);
        alarm_reset_in <= lvl;
    endtask
    // On-then-off pulse; the clear comes on the release
    task pin(input int n);
        rst_pin(1'b1);
        repeat (n) @(posedge sys_clk);
        alarm_reset_in <= 1'b0;
    endtask
    // Up and down held together for n cycles
    task keys(input int n);
        @(posedge sys_clk);
        key_up_n <= 1'b0;
        key_down_n <= 1'b0;
        repeat (n) @(posedge sys_clk);
        key_up_n <= 1'b1;
        key_down_n <= 1'b1;
    endtask
    // Menu reset function, one-cycle strobe
    task menu;
        @(posedge sys_clk);
        keypad_reset_function <= 1'b1;
        @(posedge sys_clk);
        keypad_reset_function <= 1'b0;
    endtask
    // Position preset completed, one-cycle strobe
    task preset;
        @(posedge sys_clk);
        position_preset <= 1'b1;
        @(posedge sys_clk);
        position_preset <= 1'b0;
    endtask
endmodule

// ---- tb.sv ----
// Self-checking bench for the alarm latch
`timescale 1ns/10ps
`include "dal_regs.vh"
module tb;
    logic sys_clk = 0, rst, psel, penable, pwrite, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, rd;
    logic [25:0] alarm_cond;
    wire [31:0] prdata;
    wire [25:0] alarm_r;
    wire [7:0] disp_code_r;
    wire pready, pslverr, disp_alarm_r, reset_done_r, irq_r;
    wire alarm_reset_in, key_up_n, key_down_n;
    wire keypad_reset_function, position_preset;
    int err_total = 0, checks_done = 0, cyc = 0;
    // Short hold count keeps the two-key test quick
    dal_alarm_latch #(.HOLD_CYCLES(20)) u_dut (.sys_clk, .rst, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .alarm_cond, .alarm_reset_in, .key_up_n, .key_down_n,
        .keypad_reset_function, .position_preset, .disp_alarm_r,
        .disp_code_r, .alarm_r, .reset_done_r, .irq_r);
    dal_keypad_model u_kp (.sys_clk, .alarm_reset_in, .key_up_n,
        .key_down_n, .keypad_reset_function, .position_preset);
    always #2 sys_clk = ~sys_clk;
    task chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer; held until pready is seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Fault level for one cycle, then gone
    task raise(input logic [25:0] m);
        @(posedge sys_clk);
        alarm_cond <= m;
        @(posedge sys_clk);
        alarm_cond <= 26'h0;
        repeat (3) @(posedge sys_clk);
    endtask
    task alm(input logic [25:0] exp);
        repeat (4) @(posedge sys_clk);
        chk("alarm", {6'h0, alarm_r}, {6'h0, exp});
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles needed
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            test_done;
        end
    end
    initial begin
        rst <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        alarm_cond <= 26'h0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, `DAL_IRQ_MASK_OFS, 32'h0);
        chk("mask", rd, 32'h0);
        apb(1'b1, `DAL_INIT_DISP_OFS, 32'h5a);
        apb(1'b0, `DAL_INIT_DISP_OFS, 32'h0);
        chk("init", rd, 32'h5a);
        apb(1'b0, `DAL_CTRL_OFS, 32'h0);
        chk("ctrl", rd, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        chk("hole", {31'h0, er}, 32'h1);
        $display("test registers done");
        apb(1'b1, `DAL_IRQ_MASK_OFS, 32'h3);
        raise(26'h0080441);
        alm(26'h0080441);
        chk("code", {24'h0, disp_code_r}, 32'h0);
        chk("irq", {31'h0, irq_r}, 32'h1);
        apb(1'b1, `DAL_IRQ_STAT_OFS, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk("irq", {31'h0, irq_r}, 32'h0);
        u_kp.pin(4);
        alm(26'h0080040);
        chk("code", {24'h0, disp_code_r}, 32'h6);
        chk("irq", {31'h0, irq_r}, 32'h1);
        apb(1'b0, `DAL_HOLD_ALARM_OFS, 32'h0);
        chk("held", rd, 32'h0080040);
        u_kp.preset();
        alm(26'h0000040);
        u_kp.menu();
        u_kp.keys(30);
        alm(26'h0000040);
        $display("test latch done");
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        alm(26'h0);
        apb(1'b1, `DAL_INIT_DISP_OFS, 32'h5a);
        raise(26'h0000008);
        u_kp.menu();
        alm(26'h0);
        chk("code", {24'h0, disp_code_r}, 32'h5a);
        raise(26'h0000020);
        u_kp.keys(10);
        alm(26'h0000020);
        u_kp.keys(30);
        alm(26'h0);
        u_kp.rst_pin(1'b1);
        repeat (4) @(posedge sys_clk);
        raise(26'h1000000);
        repeat (8) @(posedge sys_clk);
        alm(26'h1000000);
        u_kp.rst_pin(1'b0);
        alm(26'h0);
        raise(26'h2000000);
        apb(1'b1, `DAL_CTRL_OFS, 32'h1);
        alm(26'h0);
        $display("test resets done");
        test_done;
    end
endmodule
